// *** logic/wave_port_defs.svh ***
// Constants for the waveform generator serial write port.
// Assumes inclusion by bare name from both ends.
`ifndef WAVE_PORT_DEFS_SVH
`define WAVE_PORT_DEFS_SVH

`define WORD_BITS         16
`define DEST_HI_BIT       15
`define DEST_LO_BIT       14
`define PHASE_SEL_BIT     13
`define PHASE_VAL_BITS    12
`define FREQ_PART_BITS    14
`define FREQ_FULL_BITS    28
`define CTRL_FULL28_BIT   13
`define CTRL_HALF_BIT     12
`define CTRL_FREQ_SEL_BIT 11
`define CTRL_PH_SEL_BIT   10
`define CTRL_SQUARE_BIT   5
`define CTRL_DIV2_BIT     3
`define CTRL_RESET_BIT    8
`define CTRL_RESET_VALUE  16'h0000
`define LINK_MAX_MHZ      40
`define SYS_CLK_MHZ       20
`define LINK_DIV_HALF     1
`define BIT_COUNT_W       5

`endif

// *** logic/wave_port_pkg.sv ***
// Types shared by both ends of the serial write port.
// Assumes nothing beyond the constants header.
package wave_port_pkg;
    typedef enum logic [1:0] {
        DEST_CTRL   = 2'b00,
        DEST_FREQ_A = 2'b01,
        DEST_FREQ_B = 2'b10,
        DEST_PHASE  = 2'b11
    } dest_t;

    typedef enum logic [1:0] {
        HOST_IDLE  = 2'b00,
        HOST_SHIFT = 2'b01,
        HOST_GAP   = 2'b10,
        HOST_END   = 2'b11
    } host_state_t;
endpackage : wave_port_pkg

// *** logic/wave_link_if.sv ***
// Three-wire write link between host and waveform generator.
// Assumes the bench instances it and drives nothing itself.
`timescale 1ns/1ps
interface wave_link_if;
    logic link_clk;          // Serial clock, made by the host
    logic word_frame_n;      // Active-low word frame
    logic serial_data_in;    // Serial data, MSB first

    modport host_end (
        output link_clk,
        output word_frame_n,
        output serial_data_in
    );
    modport device_end (
        input  link_clk,
        input  word_frame_n,
        input  serial_data_in
    );
endinterface : wave_link_if

// *** logic/wave_host_end.sv ***
// Host end: shifts 16-bit words out MSB first, framed by an active-low sync.
// Assumes a user that holds word_i with send_i until busy_o rises.
`timescale 1ns/1ps
`include "wave_port_defs.svh"
module wave_host_end (
    input  wire logic               sys_clk_i,    // System clock
    input  wire logic               rst_i,        // Sync reset, active high
    input  wire logic               send_i,       // Request to send one word
    input  wire logic               byte_mode_i,  // Send as two bytes with a gap
    input  wire logic [15:0]        word_i,       // Word to send
    output logic                    busy_o,       // Transfer in progress
    wave_link_if.host_end           link          // Serial link
);
    wave_port_pkg::host_state_t state;
    logic [15:0]                shreg;
    logic [`BIT_COUNT_W-1:0]    bits;
    logic                       div;
    logic                       sclk;
    logic                       fr_n;

    // Link clock from a divide-by-four of the system clock: 5 MHz, under the limit
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            div <= 1'b0;
        else
            div <= ~div;
    end

    // Serial clock rests high outside shifting data changes on rising edge, stable at fall
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= wave_port_pkg::HOST_IDLE;
            sclk  <= 1'b1;
            fr_n  <= 1'b1;
            shreg <= 16'h0000;
            bits  <= 5'h00;
        end else if (div) begin
            case (state)
                wave_port_pkg::HOST_IDLE: begin
                    if (send_i) begin
                        fr_n  <= 1'b0;    // Frame held low for the whole word
                        shreg <= word_i;  // MSB goes first
                        bits  <= 5'h00;
                        state <= wave_port_pkg::HOST_SHIFT;
                    end
                end
                wave_port_pkg::HOST_SHIFT: begin
                    sclk <= ~sclk;
                    if (!sclk) begin
                        shreg <= {shreg[14:0], 1'b0};
                        bits  <= bits + 5'h01;
                        if (bits == 5'h0f)
                            state <= wave_port_pkg::HOST_END;
                        else if (byte_mode_i && bits == 5'h07)
                            state <= wave_port_pkg::HOST_GAP;  // Frame stays low between bytes
                    end
                end
                wave_port_pkg::HOST_GAP: begin
                    state <= wave_port_pkg::HOST_SHIFT;        // Clock rests high in the gap
                end
                wave_port_pkg::HOST_END: begin
                    fr_n  <= 1'b1;  // Raised only after all 16 bits; active low as sent
                    state <= wave_port_pkg::HOST_IDLE;
                end
                default: state <= wave_port_pkg::HOST_IDLE;
            endcase
        end
    end

    // Busy reflects any state but idle, or a send being taken from idle, registered
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            busy_o <= 1'b0;
        else
            busy_o <= (state != wave_port_pkg::HOST_IDLE) || (send_i && div);
    end

    assign link.link_clk       = sclk;
    assign link.word_frame_n   = fr_n;
    assign link.serial_data_in = shreg[15];
endmodule : wave_host_end

// *** logic/wave_device_end.sv ***
// Device end: captures framed words on the link clock and updates the
// frequency, phase and control words in the system clock domain.
// Assumes the link clock only toggles while the frame is low or resting.
//
// Overview of operation
// - Serial clock up to 40 MHz, captured correctly
// - Clock may run free or rest between words
// - Frame low brackets exactly one 16-bit word
// - Data sampled on falling serial clock edge
// - Words arrive most significant bit first
// - Byte hosts keep frame low across two bytes
// - Clock should rest high between the bytes
// - Active-high frame sync must be inverted by host
// - Frequency choice bit picks word A or B
// - Phase choice bit picks phase word A or B
// - Square output from accumulator MSB
// - Top two bits steer word to destination
// - Bit 13 picks phase word, 12-bit value
`timescale 1ns/1ps
`include "wave_port_defs.svh"
module wave_device_end (
    input  wire logic               sys_clk_i,         // Master clock
    input  wire logic               rst_i,             // Sync reset, active high
    wave_link_if.device_end         link,              // Serial link
    output logic [27:0]             frequency_word_a,  // First frequency word
    output logic [27:0]             frequency_word_b,  // Second frequency word
    output logic [11:0]             phase_word_a,      // First phase word
    output logic [11:0]             phase_word_b,      // Second phase word
    output logic [15:0]             control_o,         // Control word
    output logic                    freq_word_choice,  // Selected frequency word
    output logic [27:0]             phase_acc_o,       // Accumulator plus phase offset
    output logic                    wave_output,       // Square wave output
    output logic                    word_strobe_o      // One-cycle pulse per accepted word
);
    // Link domain
    logic [15:0]             lk_shift;
    logic [`BIT_COUNT_W-1:0] lk_count;
    logic [15:0]             lk_word;
    logic                    lk_toggle;

    // Frame high clears the counter asynchronously; the link clock may stop
    always_ff @(negedge link.link_clk or posedge link.word_frame_n) begin
        if (link.word_frame_n) begin
            lk_count <= 5'h00;
            lk_shift <= 16'h0000;
        end else begin
            lk_shift <= {lk_shift[14:0], link.serial_data_in};  // MSB first, on falling edge
            lk_count <= (lk_count == 5'h10) ? 5'h10 : lk_count + 5'h01;
        end
    end

    // Word complete on the 16th bit; the word holds for a whole frame, so only the toggle crosses
    always_ff @(negedge link.link_clk) begin
        if (!link.word_frame_n && lk_count == 5'h0f)
            lk_word <= {lk_shift[14:0], link.serial_data_in};
    end

    // Toggle cleared by system reset directly, since the link clock may be stopped then
    always_ff @(negedge link.link_clk or posedge rst_i) begin
        if (rst_i)
            lk_toggle <= 1'b0;
        else if (!link.word_frame_n && lk_count == 5'h0f)
            lk_toggle <= ~lk_toggle;
    end

    // Toggle crosses by two flops; word is stable for a full frame after
    logic sy_t1, sy_t2, sy_t3;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sy_t1 <= 1'b0;
            sy_t2 <= 1'b0;
            sy_t3 <= 1'b0;
        end else begin
            sy_t1 <= lk_toggle;
            sy_t2 <= sy_t1;
            sy_t3 <= sy_t2;
        end
    end

    logic        got;
    logic [15:0] w;
    assign got = sy_t2 ^ sy_t3;
    assign w   = lk_word;

    // Steering by the top bits frequency halves per control bits
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            frequency_word_a <= 28'h0000000;
            frequency_word_b <= 28'h0000000;
            phase_word_a     <= 12'h000;
            phase_word_b     <= 12'h000;
            control_o        <= `CTRL_RESET_VALUE;
            word_strobe_o    <= 1'b0;
        end else begin
            word_strobe_o <= got;
            if (got) begin
                case (wave_port_pkg::dest_t'(w[`DEST_HI_BIT:`DEST_LO_BIT]))
                    wave_port_pkg::DEST_CTRL: control_o <= w;
                    wave_port_pkg::DEST_FREQ_A: begin
                        if (control_o[`CTRL_HALF_BIT] && !control_o[`CTRL_FULL28_BIT])
                            frequency_word_a[27:14] <= w[13:0];
                        else
                            frequency_word_a[13:0] <= w[13:0];
                    end
                    wave_port_pkg::DEST_FREQ_B: begin
                        if (control_o[`CTRL_HALF_BIT] && !control_o[`CTRL_FULL28_BIT])
                            frequency_word_b[27:14] <= w[13:0];
                        else
                            frequency_word_b[13:0] <= w[13:0];
                    end
                    wave_port_pkg::DEST_PHASE: begin
                        if (w[`PHASE_SEL_BIT])          // Bit 13 picks the phase word
                            phase_word_b <= w[11:0];
                        else
                            phase_word_a <= w[11:0];
                    end
                    default: control_o <= control_o;
                endcase
            end
        end
    end

    // Frequency choice follows its control bit even in internal reset; only the accumulator and phase_acc_o clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            freq_word_choice <= 1'b0;
        else
            freq_word_choice <= control_o[`CTRL_FREQ_SEL_BIT];
    end

    // Accumulator runs on selected frequency word phase offset added
    logic [27:0] acc;
    logic        div2;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || control_o[`CTRL_RESET_BIT]) begin
            acc              <= 28'h0000000;
            phase_acc_o      <= 28'h0000000;
        end else begin
            acc <= acc + (freq_word_choice ? frequency_word_b : frequency_word_a);
            phase_acc_o <= acc + {(control_o[`CTRL_PH_SEL_BIT] ? phase_word_b : phase_word_a), 16'h0000};
        end
    end

    // Square wave from accumulator MSB, optionally halved
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            div2        <= 1'b0;
            wave_output <= 1'b0;
        end else begin
            if (phase_acc_o[27] && !acc[27])
                div2 <= ~div2;
            wave_output <= control_o[`CTRL_SQUARE_BIT] &
                (control_o[`CTRL_DIV2_BIT] ? phase_acc_o[27] : div2);
        end
    end
endmodule : wave_device_end

// *** bench/wave_link_monitor.sv ***
// Checker for the three-wire write link between host and device ends.
// Assumes the bench instances it beside the link and both run on sys_clk_i.
`timescale 1ns/1ps
module wave_link_monitor (
    input  wire logic sys_clk_i,      // System clock
    input  wire logic rst_i,          // Sync reset, active high
    input  wire logic link_clk,       // Serial clock
    input  wire logic word_frame_n,   // Active-low word frame
    input  wire logic serial_data_in, // Serial data
    input  wire logic busy_o,         // Host transfer in progress
    input  wire logic word_strobe_o   // Device accepted a word
);
    logic [4:0] fall_cnt;
    logic [3:0] since_rise;
    logic       prev_clk;
    logic       full;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Falls inside a frame; cleared by the idle frame so no reset is needed
    always_ff @(posedge sys_clk_i) begin
        prev_clk <= link_clk;
        fall_cnt <= word_frame_n ? 5'h0 : fall_cnt + 5'(prev_clk & ~link_clk);
    end

    // Cycles since the frame closed, saturating so it never wraps
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) since_rise <= 4'hf;
        else if (!word_frame_n) since_rise <= 4'h0;
        else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
    end

    assign full = (fall_cnt == 5'd16);

    sequence low_half;
        !link_clk ##1 !link_clk ##1 link_clk;
    endsequence

    a_rise_full_word: assert property ($rose(word_frame_n) |-> fall_cnt == 5'd16)
        else $error("frame closed without sixteen link falls");
    a_frame_busy_host: assert property (!word_frame_n |-> busy_o)
        else $error("frame low while host not busy");
    a_data_at_fall: assert property ($fell(link_clk) |-> $stable(serial_data_in))
        else $error("data moved at the sampling fall");
    a_clock_rest_high: assert property (word_frame_n |-> link_clk)
        else $error("link clock not resting high outside frame");
    a_low_phase_len: assert property ($fell(link_clk) |-> low_half)
        else $error("link clock low phase not two cycles");
    a_strobe_after_word: assert property ($rose(full) |-> ##[1:8] word_strobe_o)
        else $error("no strobe after a full word");
    a_strobe_one_cycle: assert property (word_strobe_o |=> !word_strobe_o)
        else $error("strobe longer than one cycle");
    a_strobe_near_frame: assert property (word_strobe_o |-> since_rise <= 4'h8)
        else $error("strobe far from any frame");
endmodule : wave_link_monitor

// *** bench/waveform_gen_serial_write_port_tb_top.sv ***
// Bench: host and device joined by one link, plus a second device end fed by
// a bench driver with a free clock. Assumes the design files compile first.
`timescale 1ns/1ps
module waveform_gen_serial_write_port_tb_top;
    logic        sys_clk_i = 1'b0, rst_i = 1'b1, send_i = 1'b0, byte_mode_i = 1'b0;
    logic        busy_o, fsel, strobe, strobe2, fsel2;
    logic [15:0] word_i = 16'h0000, ctl, ctl2, mc;
    logic [27:0] fa, fb, fa2, fb2, ma, mb, pacc;
    logic        wout;
    logic [11:0] pa, pb, pa2, pb2, mp0, mp1;
    int          error_cnt = 0, total_checks = 0, n2 = 0;
    wave_link_if link ();
    wave_link_if link2 ();

    wave_host_end wave_host_end_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .send_i(send_i),
        .byte_mode_i(byte_mode_i), .word_i(word_i), .busy_o(busy_o), .link(link));
    wave_device_end wave_device_end_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link),
        .frequency_word_a(fa), .frequency_word_b(fb), .phase_word_a(pa), .phase_word_b(pb),
        .control_o(ctl), .freq_word_choice(fsel), .phase_acc_o(pacc), .wave_output(wout), .word_strobe_o(strobe));
    wave_device_end fault_wave_device_end_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link2),
        .frequency_word_a(fa2), .frequency_word_b(fb2), .phase_word_a(pa2), .phase_word_b(pb2),
        .control_o(ctl2), .freq_word_choice(fsel2), .phase_acc_o(), .wave_output(), .word_strobe_o(strobe2));
    wave_link_monitor wave_link_monitor_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clk(link.link_clk),
        .word_frame_n(link.word_frame_n), .serial_data_in(link.serial_data_in), .busy_o(busy_o),
        .word_strobe_o(strobe));

    // Clocks; the second link clock runs free, unrelated to the system clock
    always #25 sys_clk_i = ~sys_clk_i;
    always #16 link2.link_clk = ~link2.link_clk;
    always @(posedge sys_clk_i) n2 <= n2 + int'(strobe2 === 1'b1);

    task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
        total_checks++;
        if (e !== g) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_for(ref logic s, input logic v);
        for (int i = 0; i < 300 && s !== v; i++) @(posedge sys_clk_i) #1;
        chk("handshake", 28'(v), 28'(s));
    endtask : wait_for

    // Model of a frequency half write: the high half only in split mode
    function automatic logic [27:0] upd(input logic [27:0] f, input logic [15:0] w);
        upd = f;
        if (!mc[13] && mc[12]) upd[27:14] = w[13:0];
        else upd[13:0] = w[13:0];
    endfunction : upd

    task automatic send(input logic [15:0] w, input logic bm);
        @(posedge sys_clk_i);
        send_i <= 1'b1;
        word_i <= w;
        byte_mode_i <= bm;
        wait_for(busy_o, 1'b1);
        @(posedge sys_clk_i);
        send_i <= 1'b0;
        wait_for(strobe, 1'b1);
        case (w[15:14])
            2'b00: mc = w;
            2'b01: ma = upd(ma, w);
            2'b10: mb = upd(mb, w);
            default: if (w[13]) mp1 = w[11:0]; else mp0 = w[11:0];
        endcase
        repeat (2) @(posedge sys_clk_i) #1;
        chk("control", 28'(mc), 28'(ctl));
        chk("freq_a", ma, fa);
        chk("freq_b", mb, fb);
        chk("phase_a", 28'(mp0), 28'(pa));
        chk("phase_b", 28'(mp1), 28'(pb));
        chk("freq_choice", 28'(mc[11]), 28'(fsel));
        wait_for(busy_o, 1'b0);
    endtask : send

    // Bench driver on the second link: data moves on rising, frame may end early
    task automatic frame2(input int nbits, input logic [15:0] w);
        for (int i = 15; i >= 16 - nbits; i--) begin
            @(posedge link2.link_clk);
            link2.word_frame_n <= 1'b0;
            link2.serial_data_in <= w[i];
        end
        @(posedge link2.link_clk);
        link2.word_frame_n <= 1'b1;
        link2.serial_data_in <= ~link2.serial_data_in;
        repeat (20) @(posedge sys_clk_i);
    endtask : frame2

    task automatic summarize();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #400_000;
        error_cnt++;
        summarize();
    end

    initial begin
        void'($urandom(32'h82ec002b));
        {mc, ma, mb, mp0, mp1} = '0;
        link2.link_clk = 1'b1;
        link2.word_frame_n = 1'b1;
        link2.serial_data_in = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Every destination code in turn, random payloads and byte mode
        for (int i = 0; i < 24; i++) send({2'(i), 14'($urandom)}, 1'($urandom));
        // Internal reset bit holds the accumulator at zero; square output off
        send(16'h0100, 1'b0);
        chk("phase_acc", 28'h0, pacc);
        chk("wave_output", 28'h0, 28'(wout));
        frame2(8, 16'h0800);
        chk("short_ctrl", 28'h0, 28'(ctl2));
        frame2(16, 16'h4abc);
        chk("free_clk_freq", 28'h0000abc, fa2);
        frame2(15, 16'h8fff);
        chk("short_freq", 28'h0, fb2);
        chk("strobes", 28'h1, 28'(n2));
        summarize();
    end
endmodule : waveform_gen_serial_write_port_tb_top
